// >>> lcg_pkg.sv
// Constants for the gate term select block: register map, field positions, resets.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package lcg_pkg;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int SEL_W = 8;
  localparam int DATA_N = 4;
  localparam int GATE_N = 3;
  localparam int MIRROR_W = 4;

  localparam logic [APB_AW-1:0] OFF_GATE_TWO_SEL = 12'h000;
  localparam logic [APB_AW-1:0] OFF_GATE_THREE_SEL = 12'h004;
  localparam logic [APB_AW-1:0] OFF_GATE_FOUR_SEL = 12'h008;
  localparam logic [APB_AW-1:0] OFF_CELL_MIRROR = 12'h00c;
  localparam logic [APB_AW-1:0] OFF_POLARITY = 12'h010;

  localparam int POL_CELL_BIT = 7;
  localparam int POL_G2_BIT = 1;
  localparam int POL_G3_BIT = 2;
  localparam int POL_G4_BIT = 3;
  localparam logic [SEL_W-1:0] POL_WR_MASK = 8'h8e;

  localparam logic [SEL_W-1:0] SEL_POR_VAL = 8'h00;
  localparam logic [SEL_W-1:0] POL_RST_VAL = 8'h00;
  localparam logic [MIRROR_W-1:0] MIRROR_RST_VAL = 4'h0;

  typedef enum logic [1:0] {
    LCG_ST_IDLE = 2'b01,
    LCG_ST_ACCESS = 2'b10
  } lcg_apb_state_t;
endpackage : lcg_pkg

// >>> lcg_gate_if.sv
// Carrier between the register core and the gate evaluator.
// Assumes both ends sit in the same clock domain; the evaluator is combinational.
`timescale 1ns/1ps
interface lcg_gate_if;
  import lcg_pkg::*;
  logic [SEL_W-1:0] sel [GATE_N];
  logic [GATE_N-1:0] gate_inv;
  logic [DATA_N-1:0] data_true;
  logic [GATE_N-1:0] result;
  modport core (output sel, output gate_inv, output data_true, input result);
  modport eval (input sel, input gate_inv, input data_true, output result);
endinterface : lcg_gate_if

// >>> lcg_gate_eval.sv
// Combinational OR-gating of true and inverted data terms for gates two to four.
// Assumes the select and polarity values arrive from registers in the core.
`timescale 1ns/1ps
module lcg_gate_eval (
  lcg_gate_if.eval gif
);
  import lcg_pkg::*;

  // Bit 2k+1 picks data k true, bit 2k picks data k inverted
  function automatic logic term_or(input logic [SEL_W-1:0] sel, input logic [DATA_N-1:0] d);
    logic acc;
    acc = 1'b0;
    for (int k = 0; k < DATA_N; k++) begin
      acc = acc | (sel[2*k+1] & d[k]) | (sel[2*k] & ~d[k]); // R1 R2 R3 R4 R5 R6 R13
    end
    return acc;
  endfunction : term_or

  genvar g;
  generate
    for (g = 0; g < GATE_N; g++) begin : gen_gate
      assign gif.result[g] = term_or(gif.sel[g], gif.data_true) ^ gif.gate_inv[g]; // R11
    end
  endgenerate
endmodule : lcg_gate_eval

// >>> lcg_gate_select.sv
// Overview of operation
// R1: Gate two takes true data per odd bits
// R2: Gate two takes inverted data per even bits
// R3: Gate three takes true data per odd bits
// R4: Gate three takes inverted data per even bits
// R5: Gate four takes true data per odd bits
// R6: Gate four takes inverted data per even bits
// R7: Selects read/write, kept over soft reset
// R8: Mirror shows cell outputs one to four
// R9: Mirror upper four bits read zero
// R10: Mirror zero after reset, writes ignored
// R11: Gate polarity bit inverts gate result
// R12: Mirror takes cell output after polarity
// R13: Gate is OR of selected terms, else zero
// Top of the gate term select block with its APB register slave.
// Assumes an APB master; data inputs and cell outputs are synchronous to core_clk_in.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module lcg_gate_select #(
  parameter int CELL_INDEX = 0
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic soft_reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [lcg_pkg::APB_AW-1:0] paddr_in,
  input wire logic [lcg_pkg::APB_DW-1:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [lcg_pkg::APB_DW-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [lcg_pkg::DATA_N-1:0] data_true_in,
  input wire logic [lcg_pkg::MIRROR_W-1:0] cell_outputs_in,
  input wire logic cell_raw_in,
  output logic gate_two_result_out,
  output logic gate_three_result_out,
  output logic gate_four_result_out,
  output logic cell_output_out
);
  import lcg_pkg::*;

  function automatic logic reg_hit(input logic [APB_AW-1:0] addr, input logic [APB_AW-1:0] off);
    return addr == off;
  endfunction : reg_hit

  lcg_apb_state_t state;
  lcg_apb_state_t next_state;
  logic [SEL_W-1:0] gate_two_term_select;
  logic [SEL_W-1:0] gate_three_term_select;
  logic [SEL_W-1:0] gate_four_term_select;
  logic [SEL_W-1:0] polarity;
  logic [MIRROR_W-1:0] cell_output_mirror;
  logic [SEL_W-1:0] next_gate_two_term_select;
  logic [SEL_W-1:0] next_gate_three_term_select;
  logic [SEL_W-1:0] next_gate_four_term_select;
  logic [SEL_W-1:0] next_polarity;
  logic [MIRROR_W-1:0] next_cell_output_mirror;
  logic [APB_DW-1:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_gate_two;
  logic next_gate_three;
  logic next_gate_four;
  logic next_cell_output;
  logic setup;
  logic complete_wr;
  logic mapped;
  logic [SEL_W-1:0] read_byte;
  logic [MIRROR_W-1:0] mirror_src;

  lcg_gate_if gif ();

  assign gif.sel[0] = gate_two_term_select;
  assign gif.sel[1] = gate_three_term_select;
  assign gif.sel[2] = gate_four_term_select;
  assign gif.gate_inv = {polarity[POL_G4_BIT], polarity[POL_G3_BIT], polarity[POL_G2_BIT]};
  assign gif.data_true = data_true_in;

  lcg_gate_eval lcg_gate_eval_i (
    .gif(gif.eval)
  );

  assign setup = psel_in && !penable_in;
  // pready is high throughout the access phase, so the write lands on that edge
  assign complete_wr = (state == LCG_ST_ACCESS) && psel_in && penable_in && pwrite_in;
  assign mapped = reg_hit(paddr_in, OFF_GATE_TWO_SEL) || reg_hit(paddr_in, OFF_GATE_THREE_SEL) ||
                  reg_hit(paddr_in, OFF_GATE_FOUR_SEL) || reg_hit(paddr_in, OFF_CELL_MIRROR) ||
                  reg_hit(paddr_in, OFF_POLARITY);

  always_comb begin
    read_byte = 8'h00;
    if (reg_hit(paddr_in, OFF_GATE_TWO_SEL)) begin
      read_byte = gate_two_term_select; // R7
    end else if (reg_hit(paddr_in, OFF_GATE_THREE_SEL)) begin
      read_byte = gate_three_term_select; // R7
    end else if (reg_hit(paddr_in, OFF_GATE_FOUR_SEL)) begin
      read_byte = gate_four_term_select; // R7
    end else if (reg_hit(paddr_in, OFF_CELL_MIRROR)) begin
      read_byte = {4'h0, cell_output_mirror}; // R9
    end else if (reg_hit(paddr_in, OFF_POLARITY)) begin
      read_byte = polarity;
    end
  end

  always_comb begin
    mirror_src = cell_outputs_in; // R8
    // Own cell is mirrored straight from its raw output, so no extra cycle of lag
    mirror_src[CELL_INDEX] = cell_raw_in ^ polarity[POL_CELL_BIT]; // R12
  end

  always_comb begin
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata_out;
    next_gate_two_term_select = gate_two_term_select;
    next_gate_three_term_select = gate_three_term_select;
    next_gate_four_term_select = gate_four_term_select;
    next_polarity = polarity;
    next_cell_output_mirror = mirror_src; // R8
    next_gate_two = gif.result[0];
    next_gate_three = gif.result[1];
    next_gate_four = gif.result[2];
    next_cell_output = cell_raw_in ^ polarity[POL_CELL_BIT]; // R12
    case (state)
      LCG_ST_IDLE: begin
        if (setup) begin
          next_state = LCG_ST_ACCESS;
          next_pready = 1'b1;
          next_pslverr = !mapped;
          next_prdata = pwrite_in ? 32'h0000_0000 : {24'h00_0000, read_byte};
        end
      end
      LCG_ST_ACCESS: begin
        next_state = LCG_ST_IDLE;
        if (complete_wr && pstrb_in[0]) begin
          if (reg_hit(paddr_in, OFF_GATE_TWO_SEL)) begin
            next_gate_two_term_select = pwdata_in[SEL_W-1:0]; // R7
          end
          if (reg_hit(paddr_in, OFF_GATE_THREE_SEL)) begin
            next_gate_three_term_select = pwdata_in[SEL_W-1:0]; // R7
          end
          if (reg_hit(paddr_in, OFF_GATE_FOUR_SEL)) begin
            next_gate_four_term_select = pwdata_in[SEL_W-1:0]; // R7
          end
          if (reg_hit(paddr_in, OFF_POLARITY)) begin
            next_polarity = pwdata_in[SEL_W-1:0] & POL_WR_MASK;
          end
          // Mirror offset has no write path at all
        end
      end
      default: begin
        next_state = LCG_ST_IDLE;
      end
    endcase
    if (soft_reset_in) begin
      // Soft reset keeps selects and gate polarity, clears the cell polarity bit
      next_state = LCG_ST_IDLE;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      // A write caught by soft reset is dropped, even in the access phase with pready already high
      next_gate_two_term_select = gate_two_term_select; // R7
      next_gate_three_term_select = gate_three_term_select; // R7
      next_gate_four_term_select = gate_four_term_select; // R7
      next_polarity = polarity;
      next_polarity[POL_CELL_BIT] = 1'b0;
      next_cell_output_mirror = MIRROR_RST_VAL; // R10
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state <= LCG_ST_IDLE;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      // Power-on value is undefined; zero is picked so the gates start quiet
      gate_two_term_select <= SEL_POR_VAL;
      gate_three_term_select <= SEL_POR_VAL;
      gate_four_term_select <= SEL_POR_VAL;
      polarity <= POL_RST_VAL;
      cell_output_mirror <= MIRROR_RST_VAL; // R10
      gate_two_result_out <= 1'b0;
      gate_three_result_out <= 1'b0;
      gate_four_result_out <= 1'b0;
      cell_output_out <= 1'b0;
    end else begin
      state <= next_state;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      prdata_out <= next_prdata;
      gate_two_term_select <= next_gate_two_term_select;
      gate_three_term_select <= next_gate_three_term_select;
      gate_four_term_select <= next_gate_four_term_select;
      polarity <= next_polarity;
      cell_output_mirror <= next_cell_output_mirror;
      gate_two_result_out <= next_gate_two;
      gate_three_result_out <= next_gate_three;
      gate_four_result_out <= next_gate_four;
      cell_output_out <= next_cell_output;
    end
  end

  AST_G2_TRUE: assert property ( // R1
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_two_term_select == 8'h80 && !polarity[POL_G2_BIT])
      |=> gate_two_result_out == $past(data_true_in[3])
  ) else $error("gate two true data four term wrong");

  AST_G2_INV: assert property ( // R2
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_two_term_select == 8'h01 && !polarity[POL_G2_BIT])
      |=> gate_two_result_out == !$past(data_true_in[0])
  ) else $error("gate two inverted data one term wrong");

  AST_G3_TRUE: assert property ( // R3
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_three_term_select == 8'h20 && !polarity[POL_G3_BIT])
      |=> gate_three_result_out == $past(data_true_in[2])
  ) else $error("gate three true data three term wrong");

  AST_G3_INV: assert property ( // R4
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_three_term_select == 8'h04 && !polarity[POL_G3_BIT])
      |=> gate_three_result_out == !$past(data_true_in[1])
  ) else $error("gate three inverted data two term wrong");

  AST_G4_TRUE: assert property ( // R5
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_four_term_select == 8'h08 && !polarity[POL_G4_BIT])
      |=> gate_four_result_out == $past(data_true_in[1])
  ) else $error("gate four true data two term wrong");

  AST_G4_INV: assert property ( // R6
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_four_term_select == 8'h40 && !polarity[POL_G4_BIT])
      |=> gate_four_result_out == !$past(data_true_in[3])
  ) else $error("gate four inverted data four term wrong");

  AST_SEL_WRITE: assert property ( // R7
    @(posedge core_clk_in) disable iff (reset_in || soft_reset_in)
    (complete_wr && pstrb_in[0] && paddr_in == OFF_GATE_THREE_SEL)
      |=> gate_three_term_select == $past(pwdata_in[7:0])
  ) else $error("gate three select write lost");

  AST_SEL_SOFT_KEEP: assert property ( // R7
    @(posedge core_clk_in) disable iff (reset_in)
    soft_reset_in |=> $stable(gate_two_term_select) && $stable(gate_four_term_select)
  ) else $error("select changed under soft reset");

  AST_MIRROR_COPY: assert property ( // R8
    @(posedge core_clk_in) disable iff (reset_in || soft_reset_in)
    (CELL_INDEX != 3) |=> cell_output_mirror[3] == $past(cell_outputs_in[3])
  ) else $error("mirror bit three does not follow cell four");

  AST_MIRROR_UPPER: assert property ( // R9
    @(posedge core_clk_in) disable iff (reset_in || soft_reset_in)
    (state == LCG_ST_IDLE && setup && !pwrite_in && paddr_in == OFF_CELL_MIRROR)
      |=> pready_out && prdata_out[31:4] == 28'h000_0000
  ) else $error("mirror upper bits not zero");

  AST_MIRROR_RESET: assert property ( // R10
    @(posedge core_clk_in)
    (reset_in || soft_reset_in) |=> cell_output_mirror == 4'h0
  ) else $error("mirror not cleared by reset");

  AST_GATE_POLARITY: assert property ( // R11
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_two_term_select == 8'h00 && polarity[POL_G2_BIT]) |=> gate_two_result_out
  ) else $error("gate two polarity not applied");

  AST_CELL_POLARITY: assert property ( // R12
    @(posedge core_clk_in) disable iff (reset_in || soft_reset_in)
    1'b1 |=> cell_output_mirror[CELL_INDEX] ==
      ($past(cell_raw_in) ^ $past(polarity[POL_CELL_BIT]))
  ) else $error("own mirror bit not after polarity");

  AST_EMPTY_GATE: assert property ( // R13
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_four_term_select == 8'h00 && !polarity[POL_G4_BIT]) [*2] |-> !gate_four_result_out
  ) else $error("empty gate four not zero");

  AST_G2_OR: assert property ( // R13
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_two_term_select == 8'h96 && !polarity[POL_G2_BIT])
      |=> gate_two_result_out == ($past(data_true_in[3]) | ~$past(data_true_in[2]) |
                                  ~$past(data_true_in[1]) | $past(data_true_in[0]))
  ) else $error("gate two OR of four terms wrong");

  AST_G3_POLARITY: assert property ( // R11
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_three_term_select == 8'h00 && polarity[POL_G3_BIT]) |=> gate_three_result_out
  ) else $error("gate three polarity not applied");

  AST_G4_POLARITY: assert property ( // R11
    @(posedge core_clk_in) disable iff (reset_in)
    (gate_four_term_select == 8'h00 && polarity[POL_G4_BIT]) |=> gate_four_result_out
  ) else $error("gate four polarity not applied");

  AST_SEL_SOFT_KEEP3: assert property ( // R7
    @(posedge core_clk_in) disable iff (reset_in)
    soft_reset_in |=> $stable(gate_three_term_select)
  ) else $error("gate three select changed under soft reset");

  AST_UNMAPPED_ERR: assert property (
    @(posedge core_clk_in) disable iff (reset_in || soft_reset_in)
    (state == LCG_ST_IDLE && setup && !mapped)
      |=> pready_out && pslverr_out
  ) else $error("unmapped access not flagged");
endmodule : lcg_gate_select

// >>> lcg_gate_select_bench.sv
// Self-checking bench for the gate term select block, driven over APB.
// Assumes the design files are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module lcg_gate_select_bench;
  import lcg_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic soft_reset_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [APB_AW-1:0] paddr_in = '0;
  logic [APB_DW-1:0] pwdata_in = '0;
  logic [3:0] pstrb_in = 4'h0;
  logic [APB_DW-1:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [DATA_N-1:0] data_true_in = '0;
  logic [MIRROR_W-1:0] cell_outputs_in = '0;
  logic cell_raw_in = 1'b0;
  logic gate_two_result_out;
  logic gate_three_result_out;
  logic gate_four_result_out;
  logic cell_output_out;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] tbl [11] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                           8'h00, 8'hff, 8'h96};
  logic [APB_AW-1:0] sel_off [3] = '{OFF_GATE_TWO_SEL, OFF_GATE_THREE_SEL, OFF_GATE_FOUR_SEL};
  logic [7:0] last_sel [3];
  logic [31:0] rd;
  logic err;
  logic [2:0] res;
  logic [7:0] pv;
  assign res = {gate_four_result_out, gate_three_result_out, gate_two_result_out};

  lcg_gate_select lcg_gate_select_i (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .soft_reset_in(soft_reset_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .data_true_in(data_true_in),
    .cell_outputs_in(cell_outputs_in),
    .cell_raw_in(cell_raw_in),
    .gate_two_result_out(gate_two_result_out),
    .gate_three_result_out(gate_three_result_out),
    .gate_four_result_out(gate_four_result_out),
    .cell_output_out(cell_output_out)
  );

  initial begin
    forever #2 core_clk_in = ~core_clk_in;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  // Holds the request until pready is sampled high; the bench timeout ends a hang
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rdat, output logic e);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    pstrb_in <= st;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    rdat = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr8(input logic [APB_AW-1:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, {24'h0, d}, 4'hf, x, y);
  endtask : wr8

  task automatic rdchk(input string nm, input logic [APB_AW-1:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0, 4'hf, rd, err);
    `CHK(nm, ex, rd)
    `CHK("pslverr", 1'b0, err)
  endtask : rdchk

  function automatic logic gexp(input logic [7:0] s, input logic [3:0] d, input logic inv);
    logic r;
    r = 1'b0;
    for (int k = 0; k < 4; k++) begin
      r = r | (s[2*k+1] & d[k]) | (s[2*k] & ~d[k]);
    end
    return r ^ inv;
  endfunction : gexp

  task automatic settle;
    // Ends on an edge, so the next input change also lands on an edge
    repeat (2) @(posedge core_clk_in);
  endtask : settle

  initial begin
    // About eight times the expected length of all tests
    #40000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rdchk("mirror_rst", OFF_CELL_MIRROR, 32'h0);
    rdchk("pol_rst", OFF_POLARITY, 32'h0);
    $display("test reset done");
    // Each gate gets a different select so a swapped gate shows up
    for (int p = 0; p < 2; p++) begin
      pv = (p == 0) ? 8'h04 : 8'h0a;
      wr8(OFF_POLARITY, pv);
      for (int i = 0; i < 11; i++) begin
        for (int g = 0; g < 3; g++) begin
          last_sel[g] = tbl[(i + 4 * g) % 11];
          wr8(sel_off[g], last_sel[g]);
        end
        for (int g = 0; g < 3; g++) begin
          rdchk("sel_rw", sel_off[g], {24'h0, last_sel[g]});
        end
        for (int d = 0; d < 16; d++) begin
          data_true_in <= d[3:0];
          settle();
          for (int g = 0; g < 3; g++) begin
            `CHK("gate", gexp(last_sel[g], d[3:0], pv[g+1]), res[g])
          end
        end
      end
    end
    $display("test gates done");
    cell_outputs_in <= 4'b1010;
    cell_raw_in <= 1'b1;
    wr8(OFF_POLARITY, 8'h00);
    settle();
    `CHK("cell_out", 1'b1, cell_output_out)
    rdchk("mirror", OFF_CELL_MIRROR, 32'hb);
    wr8(OFF_POLARITY, 8'h80);
    settle();
    `CHK("cell_out_inv", 1'b0, cell_output_out)
    wr8(OFF_CELL_MIRROR, 8'hff);
    rdchk("mirror_ro", OFF_CELL_MIRROR, 32'ha);
    cell_outputs_in <= 4'b0101;
    cell_raw_in <= 1'b0;
    settle();
    rdchk("mirror_chg", OFF_CELL_MIRROR, 32'h5);
    $display("test mirror done");
    apb(1'b0, 12'h020, 32'h0, 4'hf, rd, err);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    apb(1'b1, OFF_GATE_TWO_SEL, 32'h33, 4'h0, rd, err);
    rdchk("strb_off", OFF_GATE_TWO_SEL, {24'h0, last_sel[0]});
    wr8(OFF_POLARITY, 8'h8e);
    @(posedge core_clk_in);
    soft_reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    soft_reset_in <= 1'b0;
    for (int g = 0; g < 3; g++) begin
      rdchk("sel_soft", sel_off[g], {24'h0, last_sel[g]});
    end
    rdchk("pol_soft", OFF_POLARITY, 32'h0e);
    $display("test soft reset done");
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rdchk("sel_por", OFF_GATE_FOUR_SEL, {24'h0, SEL_POR_VAL});
    $display("test power-on reset done");
    end_sim();
  end
endmodule : lcg_gate_select_bench
